// ---- rtl/gpx_port.sv ----
// eight-pin general purpose port with external interrupt requests
// Notes on behaviour
// RQ1: eight pins, each independently an input or an output.
// RQ2: bit x of latch, direction and option registers steers pin x.
// RQ3: input pin read returns the synchronised pin level.
// RQ4: writing the latch of an input pin leaves the pin undriven.
// RQ5: input option bit selects floating or pulled-up input.
// RQ6: input option bit set makes the pin raise its vector request.
// RQ7: each vector has its own sensitivity field.
// RQ8: codes: 00 fall and low, 01 rise, 10 fall, 11 both.
// RQ9: sensitivity writes only accepted while cpu interrupt mask is set.
// RQ10: vector fetch clears that vector's pending request.
// RQ11: changing sensitivity bits discards every pending request.
// RQ12: output pin drives the latch; read returns the latch.
// RQ13: output option selects push-pull or open-drain; one floats.
// RQ14: enabled peripheral output forces pin to output, overriding port.
// RQ15: input pin with peripheral output enabled reads peripheral value.
// RQ16: output pin feeds its latch value to the peripheral input.
// RQ17: floating input passes pin level to the peripheral input.
// RQ18: software avoids interrupt mode and pull-up on peripheral inputs.
// RQ19: software avoids bit set and clear instructions on the latch.
// RQ20: bidirectional peripheral signals use floating input mode.
// RQ21: software keeps analog and digital functions apart on a pin.
// RQ22: pin carrying an external clock uses only that function.
// RQ23: pin levels pass two flip-flops before any use.
`timescale 1ns/1ps
module gpx_port #(
    parameter int NPIN = 8,
    parameter int NVEC = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPIN-1:0] pad_in,
    output logic [NPIN-1:0] pad_out,
    output logic [NPIN-1:0] pad_oe,
    output logic [NPIN-1:0] pad_pu,
    input wire logic [NPIN-1:0] alt_out_en,
    input wire logic [NPIN-1:0] alt_out,
    output logic [NPIN-1:0] alt_in,
    input wire logic cpu_imask,
    input wire logic [NVEC-1:0] vec_fetch,
    output logic [NVEC-1:0] irq_req
);
    logic [NPIN-1:0] port_data_latch;
    logic [NPIN-1:0] port_direction;
    logic [NPIN-1:0] port_option;
    logic [2*NVEC-1:0] edge_sense_control;
    logic [NVEC-1:0] pending;
    logic [NVEC-1:0] next_pending;
    logic [NPIN-1:0] pin_s;
    logic [NVEC-1:0] hit;
    logic [NVEC-1:0] vec_en;
    logic [NPIN-1:0] next_pad_out;
    logic [NPIN-1:0] next_pad_oe;
    logic [NPIN-1:0] next_pad_pu;
    logic [NPIN-1:0] read_back;
    logic [31:0] rd_mux;

    // apb decode; zero wait states, read data captured in the setup cycle, write data in the access cycle
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_data = paddr == gpx_pkg::ADDR_DATA_LATCH;
    wire hit_dir = paddr == gpx_pkg::ADDR_DIRECTION;
    wire hit_opt = paddr == gpx_pkg::ADDR_OPTION;
    wire hit_sense = paddr == gpx_pkg::ADDR_EDGE_SENSE;
    wire hit_pend = paddr == gpx_pkg::ADDR_PENDING;
    wire mapped = hit_data || hit_dir || hit_opt || hit_sense || hit_pend;
    wire wr = access && pwrite && mapped;
    wire wr_sense_ok = wr && hit_sense && cpu_imask; // RQ9
    wire sense_change = wr_sense_ok &&
        (pwdata[2*NVEC-1:0] != edge_sense_control); // RQ11

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // pin levels synchronised before reads and edge detection
    gpx_sync #(.WIDTH(NPIN)) u_sync ( // RQ23
        .mclk(mclk),
        .rst_b(rst_b),
        .async_in(pad_in),
        .sync_out(pin_s)
    );

    // vector v watches pin v while that pin is an interrupt input
    assign vec_en = ~port_direction[NVEC-1:0] &
        port_option[NVEC-1:0]; // RQ6

    gpx_edge #(.NVEC(NVEC)) u_edge ( // RQ7 RQ8
        .mclk(mclk),
        .rst_b(rst_b),
        .lvl(pin_s[NVEC-1:0]),
        .en(vec_en),
        .code(edge_sense_control),
        .hit(hit)
    );

    // readback: latch for outputs, peripheral value or pin for inputs
    assign read_back = (port_direction & port_data_latch) |
        (~port_direction & alt_out_en & alt_out) | // RQ15
        (~port_direction & ~alt_out_en & pin_s); // RQ3 RQ12

    // peripheral input sees the latch on outputs, else the pin
    assign alt_in = (port_direction & port_data_latch) | // RQ16
        (~port_direction & pin_s); // RQ17

    // pad drive: peripheral first, then direction and open-drain
    assign next_pad_out = (alt_out_en & alt_out) |
        (~alt_out_en & port_data_latch); // RQ14 RQ12
    assign next_pad_oe = alt_out_en |
        (port_direction & ~(port_option & port_data_latch)); // RQ13 RQ4
    // pull-up only on inputs that are not taken over
    assign next_pad_pu = ~port_direction & ~alt_out_en &
        port_option; // RQ5

    // pending: set wins over fetch, a sense change discards all
    assign next_pending = sense_change ? '0 :
        ((pending & ~vec_fetch) | hit); // RQ10 RQ11

    assign rd_mux = hit_data ? {24'h00_0000, read_back} :
        hit_dir ? {24'h00_0000, port_direction} :
        hit_opt ? {24'h00_0000, port_option} :
        hit_sense ? {24'h00_0000, edge_sense_control} :
        hit_pend ? {28'h000_0000, pending} : 32'h0000_0000;

    // software-visible registers, one bit per pin, two sensitivity bits per vector
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            port_data_latch <= gpx_pkg::RST_DATA_LATCH;
            port_direction <= gpx_pkg::RST_DIRECTION;
            port_option <= gpx_pkg::RST_OPTION;
            edge_sense_control <= gpx_pkg::RST_EDGE_SENSE;
        end else begin
            if (wr && hit_data) begin
                port_data_latch <= pwdata[NPIN-1:0]; // RQ1 RQ2
            end
            if (wr && hit_dir) begin
                port_direction <= pwdata[NPIN-1:0]; // RQ1
            end
            if (wr && hit_opt) begin
                port_option <= pwdata[NPIN-1:0];
            end
            if (wr_sense_ok) begin
                edge_sense_control <= pwdata[2*NVEC-1:0]; // RQ9
            end
        end
    end

    // pending requests toward the cpu
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    assign irq_req = pending;

    // registered pad controls keep pads glitch free
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_pu <= '0;
        end else begin
            pad_out <= next_pad_out;
            pad_oe <= next_pad_oe;
            pad_pu <= next_pad_pu;
        end
    end

    // read data sampled in the setup cycle, held through access
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_sense_locked: assert property ( // RQ9
        wr && hit_sense && !cpu_imask |=> $stable(edge_sense_control))
        else $error("sensitivity changed while mask clear");

    a_sense_discard: assert property ( // RQ11
        sense_change |=> pending == '0)
        else $error("pending kept after sensitivity change");

    a_fetch_clears: assert property ( // RQ10
        vec_fetch[0] && !hit[0] && !sense_change |=> !pending[0])
        else $error("fetch did not clear request");

    a_hit_sets: assert property ( // RQ6
        hit[0] && !sense_change |=> pending[0] ##0 irq_req[0])
        else $error("qualified event lost");

    a_rise_only: assert property ( // RQ8
        vec_en[1] && edge_sense_control[3:2] == gpx_pkg::SENSE_RISE &&
        $past(pin_s[1]) && !pin_s[1] |-> !hit[1])
        else $error("falling edge taken in rise mode");

    a_input_quiet: assert property ( // RQ4
        !port_direction[0] && !alt_out_en[0] |=> !pad_oe[0])
        else $error("input pin driven");

    a_od_floats: assert property ( // RQ13
        port_direction[0] && port_option[0] && port_data_latch[0] &&
        !alt_out_en[0] |=> !pad_oe[0])
        else $error("open-drain one driven");

    a_pp_drives: assert property ( // RQ12
        port_direction[0] && !port_option[0] && !alt_out_en[0] |=>
        pad_oe[0] && pad_out[0] == $past(port_data_latch[0]))
        else $error("push-pull output wrong");

    a_alt_force: assert property ( // RQ14
        alt_out_en[0] |=> pad_oe[0] && pad_out[0] == $past(alt_out[0]))
        else $error("peripheral did not take the pin");

    a_alt_input: assert property ( // RQ16
        port_direction[0] |-> alt_in[0] == port_data_latch[0])
        else $error("peripheral input not from latch");

    a_read_pin: assert property ( // RQ3
        setup && !pwrite && hit_data && !port_direction[0] &&
        !alt_out_en[0] |=> prdata[0] == $past(pin_s[0]))
        else $error("input read not pin level");

    // level and edge qualification on all four watched vectors
    a_level_low: assert property ( // RQ8
        vec_en[0] && edge_sense_control[1:0] == gpx_pkg::SENSE_FALL_LOW &&
        !pin_s[0] |-> hit[0])
        else $error("low level not taken in code 00");

    a_rise_taken: assert property ( // RQ8
        vec_en[1] && edge_sense_control[3:2] == gpx_pkg::SENSE_RISE &&
        !$past(pin_s[1]) && pin_s[1] |-> hit[1])
        else $error("rising edge missed in rise mode");

    a_fall_only: assert property ( // RQ8
        vec_en[2] && edge_sense_control[5:4] == gpx_pkg::SENSE_FALL &&
        !$past(pin_s[2]) && pin_s[2] |-> !hit[2])
        else $error("rising edge taken in fall mode");

    a_both_edges: assert property ( // RQ8
        vec_en[3] && edge_sense_control[7:6] == gpx_pkg::SENSE_BOTH &&
        $past(pin_s[3]) != pin_s[3] |-> hit[3])
        else $error("edge missed in both mode");

    a_pend_holds: assert property ( // RQ10
        pending[1] && !vec_fetch[1] && !sense_change |=> pending[1])
        else $error("request lost without fetch");

    a_pull_input: assert property ( // RQ5
        !port_direction[2] && !alt_out_en[2] |=>
        pad_pu[2] == $past(port_option[2]))
        else $error("pull-up does not follow option");

    a_od_low: assert property ( // RQ13
        port_direction[1] && port_option[1] && !port_data_latch[1] &&
        !alt_out_en[1] |=> pad_oe[1] && !pad_out[1])
        else $error("open-drain zero not driven low");

    a_out_high: assert property ( // RQ12
        port_direction[4] && !port_option[4] && !alt_out_en[4] |=>
        pad_oe[4] && pad_out[4] == $past(port_data_latch[4]))
        else $error("upper output pin wrong");

    a_alt_upper: assert property ( // RQ14
        alt_out_en[7] |=> pad_oe[7] && pad_out[7] == $past(alt_out[7]))
        else $error("peripheral did not take upper pin");

    a_latch_write: assert property ( // RQ4
        wr && hit_data |=> port_data_latch[0] == $past(pwdata[0]))
        else $error("latch write lost");

    a_alt_readback: assert property ( // RQ15
        setup && !pwrite && hit_data && !port_direction[1] &&
        alt_out_en[1] |=> prdata[1] == $past(alt_out[1]))
        else $error("input read not peripheral value");

    // exactly two flops between pad and peripheral input; the reset
    // guard keeps the cleared synchroniser out of the first two edges
    a_float_alt_in: assert property ( // RQ17 RQ23
        $past(rst_b, 2) && !port_direction[3] |->
        alt_in[3] == $past(pad_in[3], 2))
        else $error("peripheral input not the synced pin");

    // main scenarios for coverage
    c_irq_raised: cover property (hit[0] ##1 pending[0] ##[1:8] vec_fetch[0]);
    c_sense_block: cover property (wr && hit_sense && !cpu_imask);
    c_level_refire: cover property (vec_fetch[0] && hit[0] ##1 pending[0]);
    c_alt_take: cover property (alt_out_en[2] && port_direction[2]);
    c_od_low: cover property (port_option[1] && port_direction[1] &&
        !port_data_latch[1]);
endmodule : gpx_port

// ---- rtl/gpx_pkg.sv ----
// constants shared by the general purpose port and its helpers
package gpx_pkg;
    // register byte offsets on the apb window
    localparam logic [7:0] ADDR_DATA_LATCH = 8'h00;
    localparam logic [7:0] ADDR_DIRECTION = 8'h04;
    localparam logic [7:0] ADDR_OPTION = 8'h08;
    localparam logic [7:0] ADDR_EDGE_SENSE = 8'h0C;
    localparam logic [7:0] ADDR_PENDING = 8'h10;
    // reset values
    localparam logic [7:0] RST_DATA_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h00;
    localparam logic [7:0] RST_EDGE_SENSE = 8'h00;
    // two-bit sensitivity codes, sense_code_high then sense_code_low
    localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    // width of one sensitivity field
    localparam int SENSE_W = 2;
endpackage : gpx_pkg

// ---- rtl/gpx_sync.sv ----
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gpx_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : gpx_sync

// ---- rtl/gpx_edge.sv ----
// per-vector edge or level qualifier for external interrupts
`timescale 1ns/1ps
module gpx_edge #(
    parameter int NVEC = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [NVEC-1:0] lvl,
    input wire logic [NVEC-1:0] en,
    input wire logic [2*NVEC-1:0] code,
    output logic [NVEC-1:0] hit
);
    logic [NVEC-1:0] prev;

    // one qualifying event for the given code and levels
    function automatic logic qualify(input logic [1:0] c,
                                     input logic p,
                                     input logic n);
        logic rise;
        logic fall;
        rise = !p && n;
        fall = p && !n;
        unique case (c)
            gpx_pkg::SENSE_FALL_LOW: qualify = fall || !n;
            gpx_pkg::SENSE_RISE: qualify = rise;
            gpx_pkg::SENSE_FALL: qualify = fall;
            gpx_pkg::SENSE_BOTH: qualify = rise || fall;
        endcase
    endfunction : qualify

    // previous level kept even while disabled, so enabling adds no edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= '1;
        end else begin
            prev <= lvl;
        end
    end

    always_comb begin
        for (int v = 0; v < NVEC; v++) begin
            hit[v] = en[v] && qualify(code[2*v +: 2], prev[v], lvl[v]);
        end
    end
endmodule : gpx_edge

// ---- bench/gpx_board.sv ----
// board side of the port pins: drivers, pull-ups and bare lines
`timescale 1ns/1ps
module gpx_board (
    input wire logic mclk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pu,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    logic [7:0] last = 8'h00;
    logic [7:0] bare;
    // a line nobody drives or pulls up wanders, so a stale value never reads back
    assign bare = ~pad_oe & ~ext_en;
    // plain digital levels only: no analog source, no clock on a line
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (bare & pad_pu) | (bare & ~pad_pu & ~last);
    // memory of the wire for the wandering pattern
    always_ff @(posedge mclk) begin
        last <= pad_in;
    end
endmodule : gpx_board

// ---- bench/gpx_port_tb.sv ----
// self-checking bench for the general purpose port
`timescale 1ns/1ps
module gpx_port_tb;
    logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0, pad_in, pad_out, pad_oe, pad_pu, alt_in;
    logic [7:0] alt_out_en = '0, alt_out = '0, xen = '0, xval = '0;
    logic [7:0] d, o, l, s, m, x;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, e, cpu_imask = 1;
    logic [3:0] vec_fetch = '0, irq_req;
    int miscompares = 0, checks = 0;

    // clock at 40 mhz
    always #12.5 mclk = ~mclk;

    gpx_port i_gpx_port (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe,
        .pad_pu, .alt_out_en, .alt_out, .alt_in, .cpu_imask, .vec_fetch,
        .irq_req);
    gpx_board i_gpx_board (.mclk, .pad_out, .pad_oe, .pad_pu,
        .ext_en(xen), .ext_val(xval), .pad_in);

    task automatic chk_rd(input logic [31:0] g, input logic [31:0] w);
        checks++;
        if (g !== w) begin
            miscompares++;
            $display("unexpected at %0t: read %h want %h", $time, g, w);
        end
    endtask : chk_rd

    task automatic chk_pin(input logic [7:0] g, input logic [7:0] w);
        checks++;
        if (g !== w) begin
            miscompares++;
            $display("unexpected at %0t: pins %h want %h", $time, g, w);
        end
    endtask : chk_pin

    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] dat);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        // no cycle budget here: only the watchdog ends a stuck wait
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        // idle edge so a following call never re-drives psel at once
        @(posedge mclk);
    endtask : apb

    // pending set per vector: after fall, fetch, rise, fetch
    function automatic logic [3:0] exp_irq(input logic [7:0] sv,
        input int ph);
        logic [3:0] r;
        logic [1:0] c;
        for (int v = 0; v < 4; v++) begin
            c = sv[2*v+:2];
            r[v] = ph == 0 ? c != 2'h1 : ph == 1 ? c == 2'h0
                : ph == 2 ? c != 2'h2 : 1'b0;
        end
        return r;
    endfunction : exp_irq

    task automatic end_sim;
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #250000;
        miscompares++;
        end_sim();
    end

    // main sequence
    initial begin
        q = $urandom(38);
        repeat (8) @(posedge mclk);
        rst_b <= 1;
        @(posedge mclk);
        chk_pin(pad_oe | pad_pu, 8'h00);
        apb(1, 8'h10, 32'h0000_000F);
        apb(1, 8'h14, 32'h0000_00FF);
        for (int a = 4; a < 24; a += 4) begin
            apb(0, a[7:0], 32'h0000_0000);
            chk_rd(q, 32'h0000_0000);
            chk_pin({7'h00, e}, {7'h00, a == 20});
        end
        // random modes with peripheral overrides; first pass all open-drain
        for (int i = 0; i < 16; i++) begin
            d = i ? $urandom : 8'hFF;
            o = i ? $urandom : 8'hFF;
            l = i ? $urandom : 8'hFF;
            s = i ? $urandom : 8'h00;
            alt_out_en <= s;
            alt_out <= $urandom;
            xval <= $urandom;
            xen <= ~(d | s);
            apb(1, 8'h00, 32'(l));
            apb(1, 8'h04, 32'(d));
            apb(1, 8'h08, 32'(o));
            repeat (4) @(posedge mclk);
            apb(0, 8'h00, 32'h0000_0000);
            m = ~(s & d);
            x = s | d & ~(o & l);
            chk_rd(q & {24'hFF_FFFF, m}, 32'((s & alt_out
                | ~s & (d & l | ~d & xval)) & m));
            chk_pin(pad_oe, x);
            chk_pin(pad_out & x, (s & alt_out | ~s & l) & x);
            chk_pin(pad_pu, ~d & o & ~s);
            chk_pin(alt_in & m, (d & l | ~d & (s & alt_out | ~s & xval))
                & m);
            apb(0, 8'h04, 32'h0000_0000);
            chk_rd(q, 32'(d));
            apb(0, 8'h08, 32'h0000_0000);
            chk_rd(q, 32'(o));
        end
        // interrupt inputs on pins 0 to 3 with every sensitivity code
        alt_out_en <= 8'h00;
        xen <= 8'hFF;
        apb(1, 8'h04, 32'h0000_0000);
        apb(1, 8'h08, 32'h0000_000F);
        for (int c = 0; c < 4; c++) begin
            xval <= 8'hFF;
            repeat (5) @(posedge mclk);
            for (int v = 0; v < 4; v++) s[2*v+:2] = 2'(c + v);
            apb(1, 8'h0C, 32'(s));
            cpu_imask <= 0;
            apb(1, 8'h0C, 32'(~s));
            apb(0, 8'h0C, 32'h0000_0000);
            chk_rd(q, 32'(s));
            apb(0, 8'h10, 32'h0000_0000);
            chk_rd(q, 32'h0000_0000);
            cpu_imask <= 1;
            for (int ph = 0; ph < 4; ph++) begin
                if (ph % 2) begin
                    vec_fetch <= 4'hF;
                    @(posedge mclk);
                    vec_fetch <= 4'h0;
                end else begin
                    xval <= ph ? 8'hFF : 8'hF0;
                end
                repeat (5) @(posedge mclk);
                chk_pin(8'(irq_req), 8'(exp_irq(s, ph)));
            end
            // pins left low so the next code change has something to drop
            xval <= 8'hF0;
            repeat (5) @(posedge mclk);
        end
        end_sim();
    end
endmodule : gpx_port_tb
